// *** inc/node_status_params.svh ***
// Constants for the fieldbus node status and bit-rate detection block
// Overview of operation
// - After power-up detect the bit rate; succeed only once valid frames are seen.
// - Recognise exactly 125, 250 and 500 kbit/s.
// - Both lamps flicker during bit-rate detection.
// - Without bus voltage take no part on the bus; link lamp off.
// - Node address lies in 0..63, unique, at most 64 slaves.
// - Address 127 is the factory default, meaning unassigned.
// - Revision 01 adopts host-set address at power cycle; later revisions immediately. Revision 01 here only holds it pending; reset clears it.
// - Master may set the address at run time by explicit message.
// - Operational state makes the gateway indicator steady.
// - Unit lamp flashes green in standby with bad or missing configuration.
// - Unit lamp steady green in normal operation.
// - Unit lamp flashes red on a recoverable error.
// - Unit lamp steady red on an unrecoverable fault.
// - Unit lamp flashes green and red alternately during self-test.
// - Link lamp off while offline, address check, or power missing.
// - Link lamp steady green when online with an active connection.
// - Link lamp flashes green when online without communication.
// - Link lamp flashes red when an I/O connection timed out.
// - Fatal network error stops bus traffic; link lamp steady red.
// - Access error gives error state; link lamp flashes green and red.
`ifndef NODE_STATUS_PARAMS_SVH
`define NODE_STATUS_PARAMS_SVH
`define CLK_FREQ_HZ        100000000
`define BLINK_HALF_MS      500
`define BLINK_HALF_CYC     ((`CLK_FREQ_HZ / 1000) * `BLINK_HALF_MS)
`define FLICKER_HALF_MS    50
`define FLICKER_HALF_CYC   ((`CLK_FREQ_HZ / 1000) * `FLICKER_HALF_MS)
`define BIT_NS_125K        8000
`define BIT_NS_250K        4000
`define BIT_NS_500K        2000
`define BIT_CYC_125K       (`BIT_NS_125K / 10)
`define BIT_CYC_250K       (`BIT_NS_250K / 10)
`define BIT_CYC_500K       (`BIT_NS_500K / 10)
`define BIT_TOL_CYC        8
`define FRAMES_TO_LOCK     4
`define ADDR_MAX           6'h3F
`define ADDR_DEFAULT       7'h7F
`define HW_REV_FIRST       8'h01
`define REG_CTRL           12'h000
`define REG_STATUS         12'h004
`define REG_ADDR           12'h008
`define REG_LINK           12'h00C
`define REG_UNIT           12'h010
`define CTRL_SELFTEST      0
`define CTRL_FATAL         1
`define CTRL_RECOV         2
`define CTRL_CFG_OK        3
`define CTRL_OPER          4
`define CTRL_CONN          5
`define CTRL_TMO           6
`define CTRL_ACCESS        7
`define CTRL_NETFATAL      8
`define CTRL_DUPCHK        9
`endif

// *** inc/node_status_pkg.sv ***
// Types for the fieldbus node status and bit-rate detection block
package node_status_pkg;
    typedef enum logic [1:0] {RATE_NONE, RATE_125K, RATE_250K, RATE_500K} rate_type;
    typedef enum logic [2:0] {LAMP_OFF, LAMP_GREEN, LAMP_RED, LAMP_GREEN_FLASH,
                              LAMP_RED_FLASH, LAMP_ALT_FLASH, LAMP_FLICKER} lamp_mode_type;
    typedef struct packed {
        logic green;
        logic red;
    } lamp_type;
    typedef struct packed {
        logic        sel;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] haddr;
    } ahb_req_type;
endpackage

// *** rtl/node_status.sv ***
// Node status lamps, bit-rate detection and node address handling
`timescale 1ns/1ps
`default_nettype none
`include "node_status_params.svh"
module node_status
    import node_status_pkg::*;
(
    input  wire logic        core_clk,           // Device clock, 100 MHz
    input  wire logic        rst,                // Asynchronous reset, active high
    input  wire logic        hsel,               // AHB-Lite slave select
    input  wire logic [31:0] haddr,              // AHB-Lite address
    input  wire logic [1:0]  htrans,             // AHB-Lite transfer type
    input  wire logic        hwrite,             // AHB-Lite write
    input  wire logic [2:0]  hsize,              // AHB-Lite size
    input  wire logic [31:0] hwdata,             // AHB-Lite write data
    input  wire logic        hready,             // AHB-Lite ready in
    output logic [31:0]      hrdata,             // AHB-Lite read data
    output logic             hreadyout,          // AHB-Lite ready out
    output logic             hresp,              // AHB-Lite response, always OKAY
    input  wire logic        can_rx,             // Bus receive pin
    input  wire logic        bus_power,          // Bus supply voltage present
    input  wire logic [7:0]  hw_revision,        // Hardware revision strap
    input  wire logic        host_addr_valid,    // Host unit presents a new address, pulse
    input  wire logic [6:0]  host_addr,          // Address from host unit
    input  wire logic        master_addr_valid,  // Explicit-message address set, pulse
    input  wire logic [6:0]  master_addr,        // Address from master
    input  wire logic        frame_ok,           // Controller saw a valid frame, pulse
    output logic             bus_enable,         // Node may take part on the bus
    output rate_type         bit_rate,           // Detected bit rate
    output logic [6:0]       node_address,       // Address in use
    output lamp_type         unit_health_lamp,   // Unit health lamp drive
    output lamp_type         link_health_lamp,   // Link health lamp drive
    output logic             gateway_indicator,  // Gateway indicator on host unit
    output logic             gateway_steady      // Gateway indicator steady, not flashing
);
    // Pin synchronisers
    logic [1:0] rx_sync_q;
    logic [1:0] pwr_sync_q;
    logic       rx_s;
    logic       pwr_s;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_sync_q  <= 2'h3;
            pwr_sync_q <= 2'h0;
        end else begin
            rx_sync_q  <= {rx_sync_q[0], can_rx};
            pwr_sync_q <= {pwr_sync_q[0], bus_power};
        end
    end
    assign rx_s  = rx_sync_q[1];
    assign pwr_s = pwr_sync_q[1];

    // Register bus
    ahb_req_type req_q;
    logic [9:0]  ctrl_q;
    logic        wr_go;
    logic        rd_go;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_q <= '0;
        end else if (hready) begin
            req_q <= '{sel: hsel & htrans[1], htrans: htrans, hwrite: hwrite, hsize: hsize, haddr: haddr};
        end else begin
            req_q.sel <= 1'b0;
        end
    end
    assign wr_go = req_q.sel & req_q.hwrite;
    assign rd_go = hsel & htrans[1] & ~hwrite & hready;

    // Bit-rate detection by dominant pulse width
    logic [9:0]  width_q;
    logic        rx_prev_q;
    logic [9:0]  min_q;
    rate_type    cand_q;
    rate_type    rate_q;
    logic [2:0]  frames_q;
    logic        locked;
    assign locked = (rate_q != RATE_NONE);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_prev_q <= 1'b1;
            width_q   <= '0;
            min_q     <= 10'h3FF;
        end else begin
            rx_prev_q <= rx_s;
            if (!rx_s) begin
                width_q <= (width_q == 10'h3FF) ? width_q : width_q + 10'h001;
            end else begin
                width_q <= '0;
                if (!rx_prev_q && width_q < min_q && width_q > 10'h0) begin
                    min_q <= width_q;
                end
            end
        end
    end
    function automatic rate_type classify(input logic [9:0] w);
        rate_type r;
        r = RATE_NONE;
        if (w + 10'(`BIT_TOL_CYC) >= 10'(`BIT_CYC_125K) && w <= 10'(`BIT_CYC_125K + `BIT_TOL_CYC)) begin
            r = RATE_125K;
        end else if (w + 10'(`BIT_TOL_CYC) >= 10'(`BIT_CYC_250K) && w <= 10'(`BIT_CYC_250K + `BIT_TOL_CYC)) begin
            r = RATE_250K;
        end else if (w + 10'(`BIT_TOL_CYC) >= 10'(`BIT_CYC_500K) && w <= 10'(`BIT_CYC_500K + `BIT_TOL_CYC)) begin
            r = RATE_500K;
        end
        return r;
    endfunction
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cand_q   <= RATE_NONE;
            rate_q   <= RATE_NONE;
            frames_q <= '0;
        end else if (!locked) begin
            cand_q <= classify(min_q);
            if (frame_ok && cand_q != RATE_NONE) begin
                if (frames_q == 3'(`FRAMES_TO_LOCK - 1)) begin
                    rate_q <= cand_q;
                end
                frames_q <= frames_q + 3'h1;
            end
        end
    end
    assign bit_rate = rate_q;

    // Node address
    logic [6:0] addr_q;
    logic [6:0] pend_q;
    logic       rev_first_q;
    logic       rev_taken_q;
    function automatic logic addr_ok(input logic [6:0] a);
        return (a <= {1'b0, `ADDR_MAX}) || (a == `ADDR_DEFAULT);
    endfunction
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rev_first_q <= 1'b0;
            rev_taken_q <= 1'b0;
        end else if (!rev_taken_q) begin
            rev_first_q <= (hw_revision == `HW_REV_FIRST);
            rev_taken_q <= 1'b1;
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_q <= `ADDR_DEFAULT;
            pend_q <= `ADDR_DEFAULT;
        end else begin
            if (wr_go && req_q.haddr[11:0] == `REG_ADDR && addr_ok(hwdata[6:0])) begin
                pend_q <= hwdata[6:0];
                addr_q <= hwdata[6:0];
            end else if (master_addr_valid && addr_ok(master_addr)) begin
                addr_q <= master_addr;
                pend_q <= master_addr;
            end else if (host_addr_valid && addr_ok(host_addr)) begin
                pend_q <= host_addr;
                if (!rev_first_q) begin
                    addr_q <= host_addr;
                end
            end
        end
    end
    assign node_address = addr_q;

    // Common blink timebase
    logic [25:0] blink_cnt_q;
    logic        blink_q;
    logic [22:0] flick_cnt_q;
    logic        flick_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
        end else if (blink_cnt_q == 26'(`BLINK_HALF_CYC - 1)) begin
            blink_cnt_q <= '0;
            blink_q     <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 26'h1;
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flick_cnt_q <= '0;
            flick_q     <= 1'b0;
        end else if (flick_cnt_q == 23'(`FLICKER_HALF_CYC - 1)) begin
            flick_cnt_q <= '0;
            flick_q     <= ~flick_q;
        end else begin
            flick_cnt_q <= flick_cnt_q + 23'h1;
        end
    end

    // Control register and lamp modes
    lamp_mode_type unit_mode;
    lamp_mode_type link_mode;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= '0;
        end else if (wr_go && req_q.haddr[11:0] == `REG_CTRL) begin
            ctrl_q <= hwdata[9:0];
        end
    end
    always_comb begin
        if (!locked) begin
            unit_mode = LAMP_FLICKER;
        end else if (ctrl_q[`CTRL_FATAL]) begin
            unit_mode = LAMP_RED;
        end else if (ctrl_q[`CTRL_SELFTEST]) begin
            unit_mode = LAMP_ALT_FLASH;
        end else if (ctrl_q[`CTRL_RECOV]) begin
            unit_mode = LAMP_RED_FLASH;
        end else if (!ctrl_q[`CTRL_CFG_OK] || addr_q == `ADDR_DEFAULT) begin
            unit_mode = LAMP_GREEN_FLASH;
        end else begin
            unit_mode = LAMP_GREEN;
        end
    end
    always_comb begin
        if (!locked) begin
            link_mode = LAMP_FLICKER;
        end else if (!pwr_s || ctrl_q[`CTRL_DUPCHK]) begin
            link_mode = LAMP_OFF;
        end else if (ctrl_q[`CTRL_NETFATAL]) begin
            link_mode = LAMP_RED;
        end else if (ctrl_q[`CTRL_ACCESS]) begin
            link_mode = LAMP_ALT_FLASH;
        end else if (ctrl_q[`CTRL_TMO]) begin
            link_mode = LAMP_RED_FLASH;
        end else if (!ctrl_q[`CTRL_CONN]) begin
            link_mode = LAMP_GREEN_FLASH;
        end else begin
            link_mode = LAMP_GREEN;
        end
    end
    function automatic lamp_type drive(input lamp_mode_type m, input logic b, input logic f);
        lamp_type l;
        l = '0;
        case (m)
            LAMP_OFF:         l = '0;
            LAMP_GREEN:       l = '{green: 1'b1, red: 1'b0};
            LAMP_RED:         l = '{green: 1'b0, red: 1'b1};
            LAMP_GREEN_FLASH: l = '{green: b, red: 1'b0};
            LAMP_RED_FLASH:   l = '{green: 1'b0, red: b};
            LAMP_ALT_FLASH:   l = '{green: b, red: ~b};
            LAMP_FLICKER:     l = '{green: f, red: ~f};
            default:          l = '0;
        endcase
        return l;
    endfunction
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            unit_health_lamp  <= '0;
            link_health_lamp  <= '0;
            gateway_indicator <= 1'b0;
            gateway_steady    <= 1'b0;
            bus_enable        <= 1'b0;
        end else begin
            unit_health_lamp  <= drive(unit_mode, blink_q, flick_q);
            link_health_lamp  <= drive(link_mode, blink_q, flick_q);
            gateway_steady    <= ctrl_q[`CTRL_OPER];
            gateway_indicator <= ctrl_q[`CTRL_OPER] | blink_q;
            bus_enable        <= pwr_s & ~ctrl_q[`CTRL_NETFATAL];
        end
    end

    // Read data
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hrdata <= '0;
        end else if (rd_go) begin
            case (haddr[11:0])
                `REG_CTRL:   hrdata <= {22'h0, ctrl_q};
                `REG_STATUS: hrdata <= {26'h0, rev_first_q, pwr_s, locked, bus_enable, rate_q};
                `REG_ADDR:   hrdata <= {17'h0, pend_q, 1'b0, addr_q};
                `REG_LINK:   hrdata <= {27'h0, link_health_lamp, link_mode};
                `REG_UNIT:   hrdata <= {27'h0, unit_health_lamp, unit_mode};
                default:     hrdata <= '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** test/can_master_model.sv ***
// Behavioural network master sending dominant pulses and frame strobes
`timescale 1ns/1ps
`default_nettype none
module can_master_model (
    input  wire logic        core_clk, // Device clock
    input  wire logic        run,      // Send frames while high
    input  wire logic [13:0] bit_cyc,  // Bit time in clock cycles
    output logic             can_rx,   // Bus level, recessive high
    output logic             frame_ok  // One pulse per valid frame
);
    logic [13:0] pos_q;
    initial begin
        can_rx = 1'b1;
        frame_ok = 1'b0;
    end
    // One dominant bit, two recessive, two dominant, idle up to eight bits
    always @(posedge core_clk) begin
        pos_q <= (!run || pos_q == 14'(bit_cyc * 8)) ? 14'h0 : pos_q + 14'h1;
        can_rx <= !(run && (pos_q < bit_cyc || (pos_q >= 14'(bit_cyc * 3) && pos_q < 14'(bit_cyc * 5))));
        frame_ok <= run && pos_q == 14'(bit_cyc * 8);
    end
endmodule
`default_nettype wire

// *** test/node_status_props.sv ***
// Port-level checker for the node status block
`timescale 1ns/1ps
`default_nettype none
module node_status_props
    import node_status_pkg::*;
(
    input wire logic       core_clk,          // Clock
    input wire logic       rst,               // Reset
    input wire logic       hreadyout,         // Ready out
    input wire logic       hresp,             // Response
    input wire logic       bus_power,         // Bus voltage
    input wire logic       master_addr_valid, // Master address strobe
    input wire logic [6:0] master_addr,       // Master address
    input wire logic       frame_ok,          // Frame strobe
    input wire logic       bus_enable,        // Bus use
    input wire rate_type   bit_rate,          // Rate
    input wire logic [6:0] node_address,      // Address
    input wire lamp_type   unit_health_lamp   // Unit lamp
);
    logic [2:0] frames_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Frames seen since reset, saturating
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            frames_q <= 3'h0;
        end else if (frame_ok && frames_q != 3'h7) begin
            frames_q <= frames_q + 3'h1;
        end
    end
    a_ahb_zero_wait: assert property (hreadyout)
        else $error("ready out low");
    a_ahb_okay_resp: assert property (!hresp)
        else $error("response not okay");
    a_addr_legal: assert property (node_address <= 7'h3F || node_address == 7'h7F)
        else $error("node address out of range");
    a_master_addr_take: assert property (master_addr_valid && master_addr <= 7'h3F |=>
        node_address == $past(master_addr)) else $error("master address not taken");
    a_rate_hold: assert property (bit_rate != RATE_NONE && bus_power |=> $stable(bit_rate))
        else $error("locked rate changed");
    a_lock_frames: assert property (bit_rate != RATE_NONE |-> frames_q >= 3'h4)
        else $error("rate locked without frames");
    a_flicker_lit: assert property (bit_rate == RATE_NONE && !$past(rst) |->
        unit_health_lamp.green != unit_health_lamp.red) else $error("no flicker while detecting");
    a_power_drop: assert property ((!bus_power)[*4] |=> !bus_enable)
        else $error("bus used without bus voltage");
endmodule
bind node_status node_status_props u_props (.*);
`default_nettype wire

// *** test/node_status_tb_top.sv ***
// Self-checking bench for the node status block
`timescale 1ns/1ps
`default_nettype none
module node_status_tb_top
    import node_status_pkg::*;
;
    logic        core_clk, rst, hsel, hwrite, hreadyout, hresp, can_rx, frame_ok, bus_power, run;
    logic        host_addr_valid, master_addr_valid, bus_enable, gateway_indicator, gateway_steady;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  hw_revision;
    logic [6:0]  host_addr, master_addr, node_address, a, pend;
    logic [13:0] bit_cyc;
    logic [9:0]  c;
    logic [4:0]  v;
    rate_type    bit_rate;
    lamp_type    unit_health_lamp, link_health_lamp;
    int          error_cnt, tests_run;
    wire logic   hready = hreadyout;
    node_status DUT (.*);
    can_master_model PARTNER (.*);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bail();
        error_cnt++;
        $display("[FAIL] %0t wait timed out", $time);
        conclude();
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) bail();
    endtask
    task automatic ahb(input logic wr, input logic [11:0] adr, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0, adr};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [11:0] adr, input logic [2:0] exp);
        ahb(1'b0, adr, 32'h0);
        chk(32'(rd[2:0]), 32'(exp));
    endtask
    task automatic pulse(input logic host, input logic [6:0] val);
        host_addr <= val;
        master_addr <= val;
        {host_addr_valid, master_addr_valid} <= {host, !host};
        @(posedge core_clk);
        {host_addr_valid, master_addr_valid} <= 2'b00;
        repeat (2) @(posedge core_clk);
    endtask
    function automatic logic [2:0] link_exp(input logic [9:0] k);
        if (k[9]) return 3'h0;
        if (k[8]) return 3'h2;
        if (k[7]) return 3'h5;
        if (k[6]) return 3'h4;
        return k[5] ? 3'h1 : 3'h3;
    endfunction
    function automatic logic [2:0] unit_exp(input logic [9:0] k);
        if (k[0]) return 3'h5;
        if (k[1]) return 3'h2;
        if (k[2]) return 3'h4;
        return k[3] ? 3'h1 : 3'h3;
    endfunction
    initial begin
        {hsel, hwrite, run, host_addr_valid, master_addr_valid, haddr, hwdata, htrans, host_addr, master_addr} = '0;
        bus_power = 1'b1;
        hsize = 3'h2;
        error_cnt = 0;
        tests_run = 0;
        void'($urandom(32'h95C7));
        for (int i = 0; i < 3; i++) begin
            hw_revision <= (i == 0) ? 8'h01 : 8'h02;
            bit_cyc <= 14'(14'h320 >> i);
            run <= 1'b0;
            rst <= 1'b1;
            repeat (8) @(posedge core_clk);
            rst <= 1'b0;
            @(posedge core_clk);
            rdchk(12'h010, 3'h6);
            rdchk(12'h00C, 3'h6);
            if (i == 0) chk(32'(node_address), 32'h7F);
            if (i == 1) chk(32'(node_address), 32'h7F);
            a = 7'($urandom_range(63));
            ahb(1'b1, 12'h008, 32'(a));
            ahb(1'b1, 12'h008, 32'h40 + $urandom_range(62));
            @(posedge core_clk);
            chk(32'(node_address), 32'(a));
            ahb(1'b1, 12'h008, 32'h7F);
            @(posedge core_clk);
            chk(32'(node_address), 32'h7F);
            pulse(1'b0, a ^ 7'h15);
            chk(32'(node_address), 32'(a ^ 7'h15));
            pend = 7'(a + 7'h3) & 7'h3F;
            pulse(1'b1, pend);
            chk(32'(node_address), (i == 0) ? 32'(a ^ 7'h15) : 32'(pend));
            ahb(1'b0, 12'h008, 32'h0);
            chk(32'(rd[14:8]), 32'(pend));
            run <= 1'b1;
            for (int n = 0; bit_rate === RATE_NONE; n++) begin
                if (n > 60000) bail();
                @(posedge core_clk);
            end
            chk(32'(bit_rate), 32'(i + 1));
            for (int j = 0; j < 12; j++) begin
                v = 5'(5'h10 >> (j % 6));
                c = {v | ((v - 5'h1) & 5'($urandom) & {5{v != 5'h0}}), 1'($urandom), 4'(4'h1 << (j % 5))};
                ahb(1'b1, 12'h000, 32'(c));
                rdchk(12'h00C, link_exp(c));
                rdchk(12'h010, unit_exp(c));
                if (link_exp(c) == 3'h1) chk(32'(link_health_lamp), 32'h2);
                if (link_exp(c) == 3'h2) chk(32'(link_health_lamp), 32'h1);
                chk(32'(gateway_steady), 32'(c[4]));
                if (c[4]) chk(32'(gateway_indicator), 32'h1);
                if (c[8]) chk(32'(bus_enable), 32'h0);
            end
            bus_power <= 1'b0;
            repeat (6) @(posedge core_clk);
            chk(32'(bus_enable), 32'h0);
            chk(32'(link_health_lamp), 32'h0);
            bus_power <= 1'b1;
        end
        conclude();
    end
endmodule
`default_nettype wire
